// ### spi_host_model.sv
/* Host model: mode 0 SPI master with 1, 2 or 4 lanes and the resolved pin bus.
   Assumes the port's pin outputs and enables are wired back to it. */
`timescale 1ns/1ps
module spi_host_model (
	input wire logic [3:0] io_o_i,
	input wire logic [3:0] oe_n_i,
	output logic sck_o,
	output logic cs_n_o,
	output logic [3:0] io_mix_o
);
	logic [3:0] m_io = 4'h0;
	logic [3:0] m_en = 4'h0;
	logic [7:0] dat [4];
	int b = 1;
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
	end
	// Released lanes show the inverse of the last value, so stale data cannot pass.
	assign io_mix_o = (~oe_n_i & io_o_i) | (oe_n_i & m_en & m_io) | (oe_n_i & ~m_en & ~m_io);
	task automatic xb(input logic [7:0] tx, input logic rd, output logic [7:0] rx);
		logic [7:0] sh;
		sh = tx;
		rx = 8'h00;
		m_en = (rd && b > 1) ? 4'h0 : 4'((1 << b) - 1);
		for (int i = 0; i < 8 / b; i++) begin
			m_io = 4'(sh >> (8 - b));
			sh = sh << b;
			#400 sck_o = 1'b1;
			rx = (rx << b) | 8'((b == 1) ? io_mix_o[1] : io_mix_o & 4'((1 << b) - 1));
			#400 sck_o = 1'b0;
		end
	endtask : xb
	task automatic frame(input logic wr, input logic fifo, input logic [11:0] a, input int n);
		logic [7:0] r;
		cs_n_o = 1'b0;
		#400;
		xb({wr, fifo, 2'b00, a[11:8]}, 1'b0, r);
		xb(a[7:0], 1'b0, r);
		for (int i = 0; i < n; i++) begin
			xb(dat[i], !wr, r);
			dat[i] = r;
		end
		#400 cs_n_o = 1'b1;
		#800;
	endtask : frame
endmodule : spi_host_model

// ### spi_host_port_cfg.svh
/*
 * Constants of the host SPI port and command FIFO: register indices, reset values and timing.
 * Assumes inclusion by bare name from the package and the testbench.
 */
`ifndef SPI_HOST_PORT_CFG_SVH
`define SPI_HOST_PORT_CFG_SVH

`define CLK_PERIOD_NS 100
`define TMR_TICK_NS 1000000
`define FIFO_AW 12
`define REG_LANE_WIDTH 3'h0
`define REG_WR_PTR_LO 3'h1
`define REG_WR_PTR_HI 3'h2
`define REG_RD_PTR_LO 3'h3
`define REG_RD_PTR_HI 3'h4
`define REG_TIMER_MS 3'h5
`define REG_IRQ_STATUS 3'h6
`define LANE_WIDTH_RST 2'h0
`define HDR_WRITE_BIT 7
`define HDR_FIFO_BIT 6

`endif

// ### spi_host_port_cmd_fifo.sv
/*
 * Host-facing SPI slave port (mode 0, MSB first) with the 4 Kbyte command ring buffer
 * and the millisecond interrupt timer.
 * Assumes SCK runs at most at an eighth of sys_clk; all pins are sampled by sys_clk.
 */
`timescale 1ns/1ps

//Contract
//- Reset starts single lane, MOSI in, MISO out
//- Two-bit field picks single, dual, quad
//- Lane width changes only via SPI write
//- 4 Kbyte command FIFO read in order
//- Engine advances read pointer after execution
//- Interrupt after programmed milliseconds elapse
//- Host interrupt output is active low
module spi_host_port_cmd_fifo
	import spi_host_port_pkg::*;
#(
	parameter int MS_CYCLES = `TMR_TICK_NS / `CLK_PERIOD_NS
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe_n_o,
	output logic int_n_o,
	output cmd_beat_t cmd_o,
	input wire logic cmd_ready_i
);

	localparam logic [13:0] MS_LAST = 14'(MS_CYCLES - 1);

	port_state_t st;
	port_state_t n;
	logic [7:0] mem [0:(1 << `FIFO_AW) - 1];
	logic [7:0] host_q;
	logic [7:0] eng_q;
	logic sck_rise;
	logic sck_fall;
	logic cs_low;
	logic [3:0] bpe;
	logic [3:0] cnt_n;
	logic [7:0] b;
	logic [7:0] rdata;
	logic set_irq;
	logic clr_irq;
	logic drive;

	always_comb begin
		n = st;
		n.we = 1'b0;
		n.cgap = 1'b0;
		set_irq = 1'b0;
		clr_irq = 1'b0;
		b = st.shin;
		cnt_n = {1'b0, st.bitcnt};
		n.syn1 = pin_sample_t'({io_i, cs_n_i, sck_i});
		n.syn2 = st.syn1;
		n.syn3 = st.syn2;
		sck_rise = st.syn2.sck & ~st.syn3.sck;
		sck_fall = ~st.syn2.sck & st.syn3.sck;
		cs_low = ~st.syn2.cs_n;
		case (st.lane_act)
			LANE_DUAL: bpe = 4'h2;
			LANE_QUAD: bpe = 4'h4;
			default: bpe = 4'h1;
		endcase
		if (st.addr[2:0] == `REG_LANE_WIDTH) begin
			rdata = {6'h00, st.lane_w};
		end else if (st.addr[2:0] == `REG_WR_PTR_LO) begin
			rdata = st.wr_ptr[7:0];
		end else if (st.addr[2:0] == `REG_WR_PTR_HI) begin
			rdata = {4'h0, st.wr_ptr[11:8]};
		end else if (st.addr[2:0] == `REG_RD_PTR_LO) begin
			rdata = st.rd_ptr[7:0];
		end else if (st.addr[2:0] == `REG_RD_PTR_HI) begin
			rdata = {4'h0, st.rd_ptr[11:8]};
		end else if (st.addr[2:0] == `REG_TIMER_MS) begin
			rdata = st.tms;
		end else if (st.addr[2:0] == `REG_IRQ_STATUS) begin
			rdata = {7'h00, st.irq};
		end else begin
			rdata = 8'h00;
		end
		if (st.isfifo) begin
			rdata = host_q;
		end
		// Read data is fetched two cycles after the byte ends, well before the next falling SCK.
		if (st.ld == 2'h2) begin
			n.ld = 2'h1;
		end else if (st.ld == 2'h1) begin
			n.shout = rdata;
			n.ld = 2'h0;
		end
		// Engine side: one gap cycle after each pop lets the RAM read catch up.
		if (st.cvld && cmd_ready_i) begin
			n.cvld = 1'b0;
			n.rd_ptr = st.rd_ptr + 12'h001;
			n.cgap = 1'b1;
		end else if (!st.cvld && !st.cgap && st.rd_ptr != st.wr_ptr) begin
			n.cvld = 1'b1;
			n.cdata = eng_q;
		end
		if (st.tms != 8'h00) begin
			if (st.tcyc == MS_LAST) begin
				n.tcyc = 14'h0000;
				n.tms = st.tms - 8'h01;
				set_irq = (st.tms == 8'h01);
			end else begin
				n.tcyc = st.tcyc + 14'h0001;
			end
		end
		if (!cs_low) begin
			n.phase = PH_HDR0;
			n.bitcnt = 3'h0;
			n.ld = 2'h0;
			// The new width takes effect only between frames, so no frame changes width midway.
			n.lane_act = (st.lane_w == LANE_RSVD) ? LANE_SINGLE : st.lane_w;
		end else if (sck_rise) begin
			case (st.lane_act)
				LANE_DUAL: b = {st.shin[5:0], st.syn2.io[1:0]};
				LANE_QUAD: b = {st.shin[3:0], st.syn2.io};
				default: b = {st.shin[6:0], st.syn2.io[0]};
			endcase
			n.shin = b;
			cnt_n = {1'b0, st.bitcnt} + bpe;
			n.bitcnt = cnt_n[2:0];
			if (cnt_n == 4'h8) begin
				case (st.phase)
					PH_HDR0: begin
						n.iswr = b[`HDR_WRITE_BIT];
						n.isfifo = b[`HDR_FIFO_BIT];
						n.addr[11:8] = b[3:0];
						n.phase = PH_HDR1;
					end
					PH_HDR1: begin
						n.addr[7:0] = b;
						n.phase = PH_DATA;
						n.ld = st.iswr ? 2'h0 : 2'h2;
					end
					default: begin
						n.addr = st.addr + 12'h001;
						if (!st.iswr) begin
							n.ld = 2'h2;
						end else if (st.isfifo) begin
							n.we = 1'b1;
							n.wa = st.addr;
							n.wd = b;
						end else if (st.addr[2:0] == `REG_LANE_WIDTH) begin
							n.lane_w = lane_mode_t'(b[1:0]);
						end else if (st.addr[2:0] == `REG_WR_PTR_LO) begin
							n.wr_lo = b;
						end else if (st.addr[2:0] == `REG_WR_PTR_HI) begin
							n.wr_ptr = {b[3:0], st.wr_lo};
						end else if (st.addr[2:0] == `REG_TIMER_MS) begin
							n.tms = b;
							n.tcyc = 14'h0000;
						end else if (st.addr[2:0] == `REG_IRQ_STATUS) begin
							clr_irq = b[0];
						end
					end
				endcase
			end
		end else if (sck_fall && st.bitcnt != 3'h0 && st.phase == PH_DATA && !st.iswr) begin
			n.shout = st.shout << bpe;
		end
		// A timer expiry in the same cycle as a clear still leaves the flag set.
		n.irq = set_irq | (st.irq & ~clr_irq);
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
			// Chip-select idles high; a zero here would open a phantom frame after reset.
			st.syn1.cs_n <= 1'b1;
			st.syn2.cs_n <= 1'b1;
			st.syn3.cs_n <= 1'b1;
			st.lane_w <= lane_mode_t'(`LANE_WIDTH_RST);
			st.lane_act <= lane_mode_t'(`LANE_WIDTH_RST);
		end else begin
			st <= n;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (st.we) begin
			mem[st.wa] <= st.wd;
		end
		host_q <= mem[st.addr];
		eng_q <= mem[st.rd_ptr];
	end

	always_comb begin
		drive = cs_low && st.phase == PH_DATA && !st.iswr;
		case (st.lane_act)
			LANE_DUAL: begin
				io_o = {2'b00, st.shout[7:6]};
				io_oe_n_o = drive ? 4'b1100 : 4'b1111;
			end
			LANE_QUAD: begin
				io_o = st.shout[7:4];
				io_oe_n_o = drive ? 4'b0000 : 4'b1111;
			end
			default: begin
				io_o = {2'b00, st.shout[7], 1'b0};
				io_oe_n_o = cs_low ? 4'b1101 : 4'b1111;
			end
		endcase
	end

	assign int_n_o = ~st.irq;
	assign cmd_o = '{valid: st.cvld, data: st.cdata};

	AST_SINGLE_PINS: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(st.lane_act == LANE_SINGLE && cs_low) |-> io_oe_n_o == 4'b1101)
		else $error("single lane must drive only the master-in line");
	AST_QUAD_DRIVE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(st.lane_act == LANE_QUAD && drive) |-> io_oe_n_o == 4'b0000 && io_o == st.shout[7:4])
		else $error("quad read must drive all four lanes");
	AST_LANE_FRAME: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		$changed(st.lane_act) |-> $past(st.syn2.cs_n) && (st.lane_act == $past(st.lane_w)
		|| ($past(st.lane_w) == LANE_RSVD && st.lane_act == LANE_SINGLE)))
		else $error("lane width changed inside a frame");
	AST_FIFO_WRITE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		st.we |=> mem[$past(st.wa)] == $past(st.wd))
		else $error("command byte not stored in FIFO");
	AST_RD_ADVANCE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(cmd_o.valid && cmd_ready_i) |=> st.rd_ptr == $past(st.rd_ptr) + 12'h001 && !cmd_o.valid)
		else $error("read pointer did not advance on consume");
	AST_TIMER_FIRE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		$rose(st.irq) |-> $past(st.tms) == 8'h01 && $past(st.tcyc) == MS_LAST)
		else $error("interrupt raised without timer expiry");
	AST_INT_LOW: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(st.tms == 8'h01 && st.tcyc == MS_LAST) |=> !int_n_o [*2])
		else $error("interrupt line not pulled low on expiry");
	AST_EMPTY: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(st.rd_ptr == st.wr_ptr && !st.cvld) |=> !cmd_o.valid)
		else $error("command offered from an empty FIFO");

	COV_QUAD_READ: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		st.lane_act == LANE_QUAD && drive);
	COV_CMD_POP: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		cmd_o.valid && cmd_ready_i);
	COV_TIMER_IRQ: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		$fell(int_n_o));

endmodule : spi_host_port_cmd_fifo

// ### spi_host_port_pkg.sv
/*
 * Types of the host SPI port: lane modes, transfer phases, carriers and the module state.
 * Assumes the constants header is on the include path.
 */
`include "spi_host_port_cfg.svh"

package spi_host_port_pkg;

	typedef enum logic [1:0] {
		LANE_SINGLE = 2'b00,
		LANE_DUAL = 2'b01,
		LANE_QUAD = 2'b10,
		LANE_RSVD = 2'b11
	} lane_mode_t;

	typedef enum logic [1:0] {
		PH_HDR0 = 2'b00,
		PH_HDR1 = 2'b01,
		PH_DATA = 2'b10
	} xfer_phase_t;

	typedef struct packed {
		logic [3:0] io;
		logic cs_n;
		logic sck;
	} pin_sample_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} cmd_beat_t;

	typedef struct packed {
		pin_sample_t syn1;
		pin_sample_t syn2;
		pin_sample_t syn3;
		xfer_phase_t phase;
		logic [2:0] bitcnt;
		logic [7:0] shin;
		logic [7:0] shout;
		logic iswr;
		logic isfifo;
		logic [11:0] addr;
		logic [1:0] ld;
		logic we;
		logic [11:0] wa;
		logic [7:0] wd;
		lane_mode_t lane_w;
		lane_mode_t lane_act;
		logic [7:0] wr_lo;
		logic [11:0] wr_ptr;
		logic [11:0] rd_ptr;
		logic cvld;
		logic cgap;
		logic [7:0] cdata;
		logic [7:0] tms;
		logic [13:0] tcyc;
		logic irq;
	} port_state_t;

endpackage : spi_host_port_pkg

// ### tb.sv
/* Testbench of the host SPI port: lanes, command FIFO, engine side and timer.
   Assumes the host model drives the pins and the bench plays the engine. */
`timescale 1ns/1ps
`include "spi_host_port_cfg.svh"
module tb import spi_host_port_pkg::*;;
	logic sys_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic cmd_ready_i = 1'b0;
	logic sck, cs_n, int_n;
	logic [3:0] io_bus, io_o, io_oe_n;
	cmd_beat_t cmd;
	int fail_count = 0;
	int n_checks = 0;
	always #50 sys_clk_i = ~sys_clk_i;
	spi_host_model host (.io_o_i(io_o), .oe_n_i(io_oe_n), .sck_o(sck), .cs_n_o(cs_n),
		.io_mix_o(io_bus));
	spi_host_port_cmd_fifo #(.MS_CYCLES(20)) dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
		.sck_i(sck), .cs_n_i(cs_n), .io_i(io_bus), .io_o(io_o), .io_oe_n_o(io_oe_n),
		.int_n_o(int_n), .cmd_o(cmd), .cmd_ready_i(cmd_ready_i));
	task automatic results();
		if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		host.dat[0] = d;
		host.frame(1'b1, 1'b0, {9'h0, a}, 1);
	endtask : wr_reg
	task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
		host.dat[0] = 8'h00;
		host.frame(1'b0, 1'b0, {9'h0, a}, 1);
		chk("register", host.dat[0], exp);
	endtask : rd_reg
	task automatic take(input logic [7:0] exp);
		for (int k = 0; k < 20 && cmd.valid !== 1'b1; k++) begin
			@(posedge sys_clk_i);
			#1;
		end
		chk("cmd valid", {7'h0, cmd.valid}, 8'h01);
		chk("cmd data", cmd.data, exp);
		cmd_ready_i = 1'b1;
		@(posedge sys_clk_i);
		#1 cmd_ready_i = 1'b0;
	endtask : take
	initial begin
		#2000000;
		fail_count++;
		results();
	end
	initial begin
		repeat (6) @(posedge sys_clk_i);
		#1 arst_n_i = 1'b1;
		chk("int_n", {7'h0, int_n}, 8'h01);
		chk("oe_n", {4'h0, io_oe_n}, 8'h0f);
		rd_reg(`REG_LANE_WIDTH, 8'h00);
		for (int w = 1; w < 4; w++) begin
			wr_reg(`REG_LANE_WIDTH, 8'(w));
			host.b = (w == 1) ? 2 : (w == 2) ? 4 : 1;
			rd_reg(`REG_LANE_WIDTH, 8'(w));
		end
		host.dat = '{8'h11, 8'h22, 8'h33, 8'h00};
		host.frame(1'b1, 1'b1, 12'h000, 3);
		host.frame(1'b0, 1'b1, 12'h000, 3);
		chk("fifo rd0", host.dat[0], 8'h11);
		chk("fifo rd1", host.dat[1], 8'h22);
		chk("fifo rd2", host.dat[2], 8'h33);
		// The low byte is only a shadow until the high byte commits both.
		wr_reg(`REG_WR_PTR_LO, 8'h03);
		wr_reg(`REG_WR_PTR_HI, 8'h00);
		repeat (4) @(posedge sys_clk_i);
		#1 chk("stalled", cmd.data, 8'h11);
		take(8'h11);
		take(8'h22);
		take(8'h33);
		repeat (4) @(posedge sys_clk_i);
		#1 chk("empty", {7'h0, cmd.valid}, 8'h00);
		rd_reg(`REG_RD_PTR_LO, 8'h03);
		wr_reg(`REG_TIMER_MS, 8'h05);
		chk("int early", {7'h0, int_n}, 8'h01);
		repeat (100) @(posedge sys_clk_i);
		#1 chk("int due", {7'h0, int_n}, 8'h00);
		rd_reg(`REG_IRQ_STATUS, 8'h01);
		wr_reg(`REG_IRQ_STATUS, 8'h01);
		chk("int cleared", {7'h0, int_n}, 8'h01);
		results();
	end
endmodule : tb
